// *** core/gpr_map_pkg.sv ***
/*
  Constants for the shared register partition map: APB offsets, field
  positions, reset values, widths and operand addressing modes.
  Assumes a 32-bit APB master and a single core clock.
*/
package gpr_map_pkg;
  // Widths
  localparam int NUM_W = 7;
  localparam int PHYS_W = 9;
  localparam int AR_W = 9;
  localparam int CNT_W = 7;
  localparam int MODE_W = 2;
  // Register file layout
  localparam logic [7:0] LOW_REGS = 8'h80;
  // Operand addressing modes
  localparam logic [1:0] MODE_REL = 2'h0;
  localparam logic [1:0] MODE_REL_OFF = 2'h1;
  localparam logic [1:0] MODE_ABS = 2'h2;
  localparam logic [1:0] MODE_ABS_IDX = 2'h3;
  // APB offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PRIV_BASE_OFS = 8'h08;
  // Control fields
  localparam int CTRL_SC_LSB = 0;
  localparam int CTRL_TC_LSB = 8;
  localparam int CTRL_DYN_BIT = 16;
  // Status fields
  localparam int ST_CFG_ERR_BIT = 0;
  localparam int ST_FIRST_KNOWN_BIT = 1;
  localparam int ST_FIRST_PIPE_BIT = 2;
  localparam int ST_AR_VALID_BIT = 3;
  localparam int ST_AR_LSB = 16;
  // Reset values
  localparam logic [CNT_W-1:0] SC_RST = 7'h00;
  localparam logic [CNT_W-1:0] TC_RST = 7'h04;
  localparam logic DYN_RST = 1'b0;
endpackage : gpr_map_pkg

// *** core/gpr_partition_map.sv ***
/*
  Operand address translation for a partitioned register file: shared pool,
  two clause-temporary sections (even and odd slot) and private registers,
  plus shared read/write conflict stall and an APB configuration slave.
  Assumes the scheduler re-issues an instruction answered with a stall, and
  that software drains the kernel pipeline before changing the counts.
*/
// Function
// [RULE_01] Absolute mode uses the register number 0..127 directly, no wavefront base.
// [RULE_02] Other modes add the issuing wavefront's base to form a private address.
// [RULE_03] Each source and destination operand picks its own addressing mode.
// [RULE_04] Shared count never exceeds 128 minus twice the temporary count.
// [RULE_05] Shared registers are removed from the private allocation pool.
// [RULE_06] Software programs the shared register count before using the pool.
// [RULE_07] Indexed modes: register plus instruction offset, or absolute plus index X.
// [RULE_08] Software loads index X with a move-to-index before indexed use.
// [RULE_09] Even and odd slots own separate clause-temporary sections.
// [RULE_10] Top operand numbers map to temporaries ascending; 124..127 give 0..3.
// [RULE_11] Temporary contents are not relied on past the end of a clause.
// [RULE_12] Cross-slot shared read after write in one group stalls one wavefront.
// [RULE_13] First slot given a wavefront is odd, the other slot even.
// [RULE_14] Physical order is shared, temporaries, private; absolute index reaches temps.
// [RULE_15] Shared pool and temporaries stay within the lowest 128 registers.
// [RULE_16] Software drains the pipeline before changing shared or temporary counts.
// [RULE_17] Software initialises shared and temporary registers before use.
// [RULE_18] Shared registers are available only in dynamic allocation mode.
// [RULE_19] Index register is 9 bits, set by move-to-index, kept one clause.
// [RULE_20] Four temporaries are reserved by default; the count is programmable.
// [RULE_21] With N temporaries the top N numbers select temporaries 0..N-1 per slot.
module gpr_partition_map #(
  parameter int NOPS = 3
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Instruction issue; operand NOPS-1 is the destination
  input wire logic i_issue_valid,
  input wire logic i_issue_pipe,
  input wire logic [gpr_map_pkg::PHYS_W-1:0] i_wave_base,
  input wire logic [NOPS*gpr_map_pkg::NUM_W-1:0] i_op_num,
  input wire logic [NOPS*gpr_map_pkg::MODE_W-1:0] i_op_mode,
  input wire logic [NOPS*gpr_map_pkg::NUM_W-1:0] i_op_offset,
  // Index register load and clause end
  input wire logic i_move_to_index_reg,
  input wire logic [gpr_map_pkg::AR_W-1:0] i_index_value,
  input wire logic i_clause_end,
  // Resolved addresses
  output logic o_res_valid,
  output logic o_res_stall,
  output logic o_res_odd,
  output logic o_res_mode_err,
  output logic o_res_range_err,
  output logic [NOPS*gpr_map_pkg::PHYS_W-1:0] o_res_addr
);
  import gpr_map_pkg::*;

  if (NOPS < 2 || NOPS > 8) begin : g_bad_nops
    $error("NOPS must be 2..8");
  end

  typedef struct packed {
    logic [CNT_W-1:0] sc;
    logic [CNT_W-1:0] tc;
    logic dyn;
    logic cfg_err;
    logic [AR_W-1:0] address_index_x;
    logic ar_valid;
    logic first_known;
    logic first_pipe;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic res_valid;
    logic res_stall;
    logic res_odd;
    logic res_mode_err;
    logic res_range_err;
    logic [NOPS*PHYS_W-1:0] res_addr;
    logic wr_pend;
    logic wr_odd;
    logic [PHYS_W-1:0] wr_addr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Resolve one operand to a 10-bit physical address; bit 9 flags overflow
  function automatic logic [PHYS_W:0] resolve(input logic [NUM_W-1:0] num,
      input logic [MODE_W-1:0] mode, input logic [NUM_W-1:0] off,
      input logic [CNT_W-1:0] sc, input logic [CNT_W-1:0] tc, input logic odd,
      input logic [PHYS_W-1:0] base, input logic [AR_W-1:0] arx, input logic dyn);
    logic [PHYS_W:0] a;
    logic [7:0] top;
    a = '0;
    top = LOW_REGS - {1'b0, tc};
    if (dyn && mode == MODE_ABS) begin
      a = {3'h0, num}; // [RULE_01]
    end else if (dyn && mode == MODE_ABS_IDX) begin
      a = {3'h0, num} + {1'b0, arx}; // [RULE_07] [RULE_14]
    end else if ({1'b0, num} >= top) begin
      // Even section first, odd section after it
      a = {3'h0, sc} + (odd ? {3'h0, tc} : 10'h000)
          + ({3'h0, num} - {2'h0, top}); // [RULE_09] [RULE_10] [RULE_21]
    end else begin
      a = {3'h0, sc} + {2'h0, tc, 1'b0} + {1'b0, base} + {3'h0, num}; // [RULE_02] [RULE_05]
      if (mode == MODE_REL_OFF) begin
        a = a + {3'h0, off}; // [RULE_07]
      end
    end
    return a;
  endfunction : resolve

  logic [NOPS*(PHYS_W+1)-1:0] addr_w;
  logic issue_odd;
  assign issue_odd = !st_r.first_known || (i_issue_pipe == st_r.first_pipe); // [RULE_13]

  // Per-operand translation, each with its own mode
  genvar g;
  generate
    for (g = 0; g < NOPS; g++) begin : g_op
      assign addr_w[g*(PHYS_W+1) +: PHYS_W+1] = resolve(i_op_num[g*NUM_W +: NUM_W],
          i_op_mode[g*MODE_W +: MODE_W], i_op_offset[g*NUM_W +: NUM_W], st_r.sc, st_r.tc,
          issue_odd, i_wave_base, st_r.address_index_x, st_r.dyn); // [RULE_03]
    end
  endgenerate

  logic apb_setup;
  logic [8:0] ctrl_sum;
  assign apb_setup = i_psel && !i_penable && !st_r.pready;
  // Nine bits so that large counts cannot wrap below the limit
  assign ctrl_sum = {2'h0, i_pwdata[CTRL_SC_LSB +: CNT_W]}
      + {1'b0, i_pwdata[CTRL_TC_LSB +: CNT_W], 1'b0};

  always_comb begin
    logic conflict;
    logic range_err;
    logic mode_err;
    logic [PHYS_W:0] a;
    logic [MODE_W-1:0] m;
    conflict = 1'b0;
    range_err = 1'b0;
    mode_err = 1'b0;
    a = '0;
    m = '0;
    st_nxt = st_r;
    // APB slave: answer in the first access cycle
    st_nxt.pready = apb_setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (apb_setup) begin
      case (i_paddr)
        CTRL_OFS: begin
          st_nxt.prdata[CTRL_SC_LSB +: CNT_W] = st_r.sc;
          st_nxt.prdata[CTRL_TC_LSB +: CNT_W] = st_r.tc;
          st_nxt.prdata[CTRL_DYN_BIT] = st_r.dyn;
          if (i_pwrite) begin
            if (ctrl_sum <= {1'b0, LOW_REGS}) begin
              st_nxt.sc = i_pwdata[CTRL_SC_LSB +: CNT_W]; // [RULE_04] [RULE_15] [RULE_20]
              st_nxt.tc = i_pwdata[CTRL_TC_LSB +: CNT_W];
              st_nxt.dyn = i_pwdata[CTRL_DYN_BIT];
              st_nxt.cfg_err = 1'b0;
            end else begin
              st_nxt.cfg_err = 1'b1; // [RULE_04]
              st_nxt.pslverr = 1'b1;
            end
          end
        end
        STATUS_OFS: begin
          st_nxt.prdata[ST_CFG_ERR_BIT] = st_r.cfg_err;
          st_nxt.prdata[ST_FIRST_KNOWN_BIT] = st_r.first_known;
          st_nxt.prdata[ST_FIRST_PIPE_BIT] = st_r.first_pipe;
          st_nxt.prdata[ST_AR_VALID_BIT] = st_r.ar_valid;
          st_nxt.prdata[ST_AR_LSB +: AR_W] = st_r.address_index_x;
          st_nxt.pslverr = i_pwrite;
        end
        PRIV_BASE_OFS: begin
          st_nxt.prdata[7:0] = {1'b0, st_r.sc} + {st_r.tc, 1'b0}; // [RULE_05]
          st_nxt.pslverr = i_pwrite;
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Index register lives for one clause
    if (i_clause_end) begin
      st_nxt.address_index_x = '0; // [RULE_19] [RULE_11]
      st_nxt.ar_valid = 1'b0;
    end else if (i_move_to_index_reg) begin
      st_nxt.address_index_x = i_index_value; // [RULE_19]
      st_nxt.ar_valid = 1'b1;
    end
    // Issue: shared read by the other slot right after a shared write stalls
    for (int k = 0; k < NOPS; k++) begin
      a = addr_w[k*(PHYS_W+1) +: PHYS_W+1];
      m = i_op_mode[k*MODE_W +: MODE_W];
      if (a[PHYS_W]) begin
        range_err = 1'b1;
      end
      if (!st_r.dyn && m[1]) begin
        mode_err = 1'b1; // [RULE_18]
      end
      if (k < NOPS-1 && st_r.wr_pend && st_r.wr_odd != issue_odd && st_r.dyn && m[1]
          && a[PHYS_W-1:0] == st_r.wr_addr) begin
        conflict = 1'b1; // [RULE_12]
      end
    end
    st_nxt.wr_pend = 1'b0;
    st_nxt.res_valid = 1'b0;
    st_nxt.res_stall = 1'b0;
    if (i_issue_valid) begin
      st_nxt.res_addr = '0;
      for (int k = 0; k < NOPS; k++) begin
        st_nxt.res_addr[k*PHYS_W +: PHYS_W] = addr_w[k*(PHYS_W+1) +: PHYS_W];
      end
      st_nxt.res_odd = issue_odd;
      st_nxt.res_mode_err = mode_err;
      st_nxt.res_range_err = range_err;
      st_nxt.res_stall = conflict; // [RULE_12]
      st_nxt.res_valid = !conflict;
      if (!st_r.first_known) begin
        st_nxt.first_known = 1'b1; // [RULE_13]
        st_nxt.first_pipe = i_issue_pipe;
      end
      a = addr_w[(NOPS-1)*(PHYS_W+1) +: PHYS_W+1];
      m = i_op_mode[(NOPS-1)*MODE_W +: MODE_W];
      if (!conflict && st_r.dyn && m[1] && {1'b0, a} < {4'h0, st_r.sc}) begin
        st_nxt.wr_pend = 1'b1; // [RULE_12]
        st_nxt.wr_odd = issue_odd;
        st_nxt.wr_addr = a[PHYS_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_r <= '0;
      st_r.sc <= SC_RST;
      st_r.tc <= TC_RST; // [RULE_20]
      st_r.dyn <= DYN_RST;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_pready = st_r.pready;
  assign o_prdata = st_r.prdata;
  assign o_pslverr = st_r.pslverr;
  assign o_res_valid = st_r.res_valid;
  assign o_res_stall = st_r.res_stall;
  assign o_res_odd = st_r.res_odd;
  assign o_res_mode_err = st_r.res_mode_err;
  assign o_res_range_err = st_r.res_range_err;
  assign o_res_addr = st_r.res_addr;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_cfg_limit: assert property ({2'h0, st_r.sc} + {1'b0, st_r.tc, 1'b0} // [RULE_04]
      <= {1'b0, LOW_REGS})
    else $error("shared plus temporaries exceed low registers");
  a_abs_direct: assert property (i_ce && i_issue_valid && st_r.dyn // [RULE_01]
      && i_op_mode[MODE_W-1:0] == MODE_ABS
      |=> o_res_addr[PHYS_W-1:0] == {2'h0, $past(i_op_num[NUM_W-1:0])})
    else $error("absolute operand not passed through");
  a_rel_base: assert property (i_ce && i_issue_valid && i_op_mode[MODE_W-1:0] == MODE_REL // [RULE_02]
      && {1'b0, i_op_num[NUM_W-1:0]} < LOW_REGS - {1'b0, st_r.tc}
      |=> o_res_addr[PHYS_W-1:0] == PHYS_W'({2'h0, $past(st_r.sc)} + {1'b0, $past(st_r.tc), 1'b0}
        + $past(i_wave_base) + {2'h0, $past(i_op_num[NUM_W-1:0])}))
    else $error("relative operand missing base");
  a_idx_x: assert property (i_ce && i_issue_valid && st_r.dyn // [RULE_07]
      && i_op_mode[MODE_W-1:0] == MODE_ABS_IDX
      |=> o_res_addr[PHYS_W-1:0] == PHYS_W'({2'h0, $past(i_op_num[NUM_W-1:0])}
        + $past(st_r.address_index_x)))
    else $error("index x not added");
  a_temp_map: assert property (i_ce && i_issue_valid && st_r.tc == 7'h04 // [RULE_10]
      && i_op_mode[MODE_W-1:0] == MODE_REL && i_op_num[NUM_W-1:0] == 7'h7c
      |=> o_res_addr[PHYS_W-1:0] == {2'h0, $past(st_r.sc)} + (o_res_odd ? 9'h004 : 9'h000))
    else $error("first temporary misplaced");
  a_stall_conflict: assert property (o_res_stall |-> !o_res_valid // [RULE_12]
      && $past(st_r.wr_pend) && $past(st_r.wr_odd) != o_res_odd)
    else $error("stall without cross-slot shared write");
  a_dyn_only: assert property (i_ce && i_issue_valid && !st_r.dyn // [RULE_18]
      && i_op_mode[MODE_W-1:0] == MODE_ABS |=> o_res_mode_err)
    else $error("shared access outside dynamic mode not flagged");
  a_ar_clause: assert property (i_ce && i_clause_end |=> !st_r.ar_valid // [RULE_19]
      && st_r.address_index_x == '0)
    else $error("index register survived clause end");
  a_first_odd: assert property (i_ce && i_issue_valid && !st_r.first_known // [RULE_13]
      |=> o_res_odd && st_r.first_pipe == $past(i_issue_pipe))
    else $error("first slot not odd");

  c_stall: cover property (o_res_stall ##1 o_res_valid);
  c_mix: cover property (o_res_valid && $past(i_op_mode[MODE_W-1:0]) == MODE_ABS
      && $past(i_op_mode[(NOPS-1)*MODE_W +: MODE_W]) == MODE_REL);
  c_cfg_err: cover property (o_pready && o_pslverr && st_r.cfg_err);
  c_even: cover property (o_res_valid && !o_res_odd);
endmodule : gpr_partition_map

// *** verif/issue_model.sv ***
/*
  Scheduler and ALU pipeline stand-in: drives instruction issue, operands
  and index loads. Assumes the bench calls drive once, just after a rising edge.
*/
module issue_model #(
  parameter int NOPS = 3
) (
  // Issue
  output logic o_issue_valid,
  output logic o_issue_pipe,
  output logic [gpr_map_pkg::PHYS_W-1:0] o_wave_base,
  output logic [NOPS*gpr_map_pkg::NUM_W-1:0] o_op_num,
  output logic [NOPS*gpr_map_pkg::MODE_W-1:0] o_op_mode,
  output logic [NOPS*gpr_map_pkg::NUM_W-1:0] o_op_offset,
  // Index register
  output logic o_move_to_index_reg,
  output logic [gpr_map_pkg::AR_W-1:0] o_index_value,
  output logic o_clause_end
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpr_map_pkg::*;
  initial drive('0, '0, '0, '0, '0, '0, '0, '0, '0);
  task automatic drive(input logic v, input logic p, input logic [PHYS_W-1:0] base,
      input logic [NOPS*NUM_W-1:0] num, input logic [NOPS*MODE_W-1:0] mode,
      input logic [NOPS*NUM_W-1:0] off, input logic mv, input logic [AR_W-1:0] val,
      input logic ce);
    o_issue_valid <= v;
    o_issue_pipe <= p;
    o_wave_base <= base;
    o_op_num <= num;
    o_op_mode <= mode;
    o_op_offset <= off;
    o_move_to_index_reg <= mv;
    o_index_value <= val;
    o_clause_end <= ce;
  endtask : drive
endmodule : issue_model

// *** verif/tb_shared_gpr_partition_map.sv ***
/*
  Bench for gpr_partition_map: APB setup, random operand translation against
  a reference function, index loads and stalls. Assumes issue_model as scheduler.
*/
module tb_shared_gpr_partition_map;
  timeunit 1ns;
  timeprecision 1ps;
  import gpr_map_pkg::*;
  localparam int NOPS = 3;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic iv, ip, mv, cend, rv, rs, rodd, rme, rre;
  logic [PHYS_W-1:0] wbase;
  logic [AR_W-1:0] ival;
  logic [NOPS*NUM_W-1:0] onum, ooff, dnum, doff;
  logic [NOPS*MODE_W-1:0] omode, dmode;
  logic [NOPS*PHYS_W-1:0] raddr, ea;
  int n_errors = 0, samples_checked = 0, seed = 82, sc = 0, tc = 4, first_p = -1;
  int cfg[6][3] = '{'{16, 4, 1}, '{120, 4, 1}, '{0, 4, 0}, '{40, 8, 1}, '{2, 0, 1}, '{16, 4, 1}};
  logic dyn = 0, pend = 0, est = 0, eodd, eme, ere, pav = 0, pap, dn, dp;
  logic [9:0] paa;
  logic [8:0] dbase;
  logic [AR_W-1:0] arx = '0;
  logic ce = 1'b1;
  gpr_partition_map #(.NOPS(NOPS)) dut (
    .i_sys_clk(clk), .i_srst(srst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_issue_valid(iv), .i_issue_pipe(ip),
    .i_wave_base(wbase), .i_op_num(onum), .i_op_mode(omode), .i_op_offset(ooff),
    .i_move_to_index_reg(mv), .i_index_value(ival), .i_clause_end(cend),
    .o_res_valid(rv), .o_res_stall(rs), .o_res_odd(rodd), .o_res_mode_err(rme),
    .o_res_range_err(rre), .o_res_addr(raddr));
  issue_model #(.NOPS(NOPS)) u_sched (
    .o_issue_valid(iv), .o_issue_pipe(ip), .o_wave_base(wbase), .o_op_num(onum),
    .o_op_mode(omode), .o_op_offset(ooff), .o_move_to_index_reg(mv),
    .o_index_value(ival), .o_clause_end(cend));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_w
  task automatic cmp_f(input string what, input logic exp, input logic got);
    cmp_w(what, {31'h0, exp}, {31'h0, got});
  endtask : cmp_f
  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic [31:0] mask, input logic [31:0] exp, input logic eerr);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    cmp_f("pready", 1'b1, pready);
    cmp_f("pslverr", eerr, pslverr);
    cmp_w("prdata", exp, prdata & mask);
    {psel, penable} <= 2'h0;
  endtask : reg_acc
  function automatic logic [9:0] ref_addr(input logic [1:0] md, input logic [6:0] num,
      input logic [6:0] off, input logic odd, input logic [8:0] base);
    logic [1:0] m;
    m = (md[1] && !dyn) ? MODE_REL : md;
    if (m == MODE_ABS) return 10'(int'(num));
    if (m == MODE_ABS_IDX) return 10'(int'(num) + int'(arx));
    if (int'(num) >= 128 - tc) return 10'(sc + (odd ? tc : 0) + int'(num) - 128 + tc);
    return 10'(sc + 2 * tc + int'(base) + int'(num) + (m == MODE_REL_OFF ? int'(off) : 0));
  endfunction : ref_addr
  task automatic run(input int count, input logic hit);
    logic [9:0] a;
    logic [31:0] r;
    logic mvx, cex, qp, qs, qo, qme, qre;
    logic [NOPS*PHYS_W-1:0] qa;
    for (int i = 0; i <= count; i++) begin
      @(posedge clk);
      // Expectation of the instruction taken at this edge, checked at the negedge
      {qp, qs, qo, qme, qre, qa} = {pend, est, eodd, eme, ere, ea};
      r = $random(seed);
      {mvx, cex} = 2'h0;
      if (!(pend && est)) begin
        dn = (i < count) && r[1:0] != 2'h0;
        dp = r[2];
        dbase = 9'($random(seed));
        doff = (NOPS*NUM_W)'($random(seed));
        dmode = (NOPS*MODE_W)'($random(seed));
        for (int k = 0; k < NOPS; k++) begin
          dnum[k*NUM_W+:NUM_W] = r[8+k] ? 7'($random(seed)) : 7'(r[13+k*2+:2]);
        end
        if (hit && i < 2) begin
          {dn, dp, dnum} = {1'b1, i[0], {NOPS{7'h05}}};
          dmode = (i == 0) ? {MODE_ABS, MODE_REL, MODE_REL} : {MODE_REL, MODE_REL, MODE_ABS};
        end
        mvx = !dn && r[5];
        cex = !dn && r[6] && r[7];
        arx = cex ? '0 : (mvx ? r[31:23] : arx);
      end
      pend = dn;
      first_p = (dn && first_p < 0) ? int'(dp) : first_p;
      eodd = (int'(dp) == first_p);
      {est, eme, ere} = 3'h0;
      for (int k = 0; k < NOPS; k++) begin
        a = ref_addr(dmode[k*MODE_W+:MODE_W], dnum[k*NUM_W+:NUM_W], doff[k*NUM_W+:NUM_W],
            eodd, dbase);
        ea[k*PHYS_W+:PHYS_W] = a[8:0];
        ere = ere | a[9];
        eme = eme | (dmode[k*MODE_W+1] && !dyn);
        est = est | (k < NOPS - 1 && pav && pap != dp && dyn && dmode[k*MODE_W+1]
            && a[8:0] == paa[8:0]);
      end
      pav = dn && !est && dyn && dmode[(NOPS-1)*MODE_W+1] && a < sc;
      {pap, paa} = {dp, a};
      u_sched.drive(dn, dp, dbase, dnum, dmode, doff, mvx, r[31:23], cex);
      @(negedge clk);
      cmp_f("res_valid", qp && !qs, rv);
      cmp_f("res_stall", qp && qs, rs);
      if (qp) begin
        cmp_f("res_odd", qo, rodd);
        cmp_f("mode_err", qme, rme);
        cmp_f("range_err", qre, rre);
        cmp_w("res_addr", 32'(qa), 32'(raddr));
      end
    end
  endtask : run
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    reg_acc(1'b0, CTRL_OFS, '0, '1, {15'h0, DYN_RST, 1'b0, TC_RST, 1'b0, SC_RST}, 1'b0);
    reg_acc(1'b0, PRIV_BASE_OFS, '0, '1, 32'h8, 1'b0);
    reg_acc(1'b0, 8'h0c, '0, '0, '0, 1'b1);
    reg_acc(1'b1, STATUS_OFS, '0, '0, '0, 1'b1);
    reg_acc(1'b1, CTRL_OFS, 32'h10479, '0, '0, 1'b1);
    reg_acc(1'b1, CTRL_OFS, 32'h7f7f, '0, '0, 1'b1);
    // Issue and index load while frozen must leave no trace
    ce <= 1'b0;
    u_sched.drive(1'b1, 1'b1, '0, '0, '0, '0, 1'b1, 9'h1aa, 1'b0);
    repeat (3) @(posedge clk);
    u_sched.drive('0, '0, '0, '0, '0, '0, '0, '0, '0);
    ce <= 1'b1;
    reg_acc(1'b0, STATUS_OFS, '0, 32'h1ff000f, 32'h1, 1'b0);
    reg_acc(1'b0, CTRL_OFS, '0, '1, 32'h400, 1'b0);
    $display("Test reset and refusal done");
    for (int c = 0; c < 6; c++) begin
      {sc, tc, dyn} = {cfg[c][0], cfg[c][1], cfg[c][2][0]};
      reg_acc(1'b1, CTRL_OFS, 32'((int'(dyn) << CTRL_DYN_BIT) | (tc << CTRL_TC_LSB) | sc),
          '0, '0, 1'b0);
      reg_acc(1'b0, PRIV_BASE_OFS, '0, '1, 32'(sc + 2 * tc), 1'b0);
      run(60, c == 5);
      reg_acc(1'b0, STATUS_OFS, '0, 32'h1ff0000, 32'(arx) << ST_AR_LSB, 1'b0);
      $display("Test config %0d done", c);
    end
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected done seen timeout");
    final_report();
  end
endmodule : tb_shared_gpr_partition_map
